// ==== aca_arq.sv ====
/*
 * Acknowledged connectionless UI exchange engine: polled UI sends with
 * per-destination retry timers, busy station record and URR/URNR
 * replies to polled UI commands. Assumes framing, address-list parsing
 * and validity checks are done upstream; one PDU in or out per cycle.
 */
// Overview of operation
// - Sending a polled UI starts that exchange's timer and zeroes its count.
// - Unanswered expiry resends the UI, bumps its count, reloads its timer.
// - Resends drop group, global and already answered destinations.
// - Address 3 rides on resends; no resend without a non-3 destination.
// - Resends repeat until the count equals N4, then ack failure goes up.
// - Each polled exchange with each destination has its own count.
// - Timers and counts of different exchanges never disturb each other.
// - A URNR answer to a polled UI marks the answering station busy.
// - No UI, first send or resend, goes to a busy station until cleared.
// - A valid polled UI naming this station gets URR back to its source.
// - A URR with F set is sent only in answer to a polled UI.
// - When enabled and locally busy, the answer is URNR with F set instead.
// - After a polled UI the sender awaits URR or URNR from each addressed station.
// - Group, global and address 3 destinations never hold an exchange open.
// - An answer stops the matching timer and zeroes its count.
`timescale 1ns/100ps
module aca_arq
  import aca_pkg::*;
#(
  parameter int NUM_SLOTS = NUM_SLOTS_DEF,
  parameter int NUM_BUSY  = NUM_BUSY_DEF
) (
  input  wire logic               clk_in,
  input  wire logic               reset_n_in,
  input  wire logic [TIMER_W-1:0] ack_period_in,
  input  wire logic [CNT_W-1:0]   n4_in,
  input  wire logic               local_busy_in,
  input  wire logic               urnr_enable_in,
  input  wire logic               send_req_in,
  input  wire logic [ADDR_W-1:0]  send_addr_in,
  input  wire aca_dest_e          send_kind_in,
  input  wire logic               send_incl3_in,
  output logic                    send_ready_out,
  input  wire logic               busy_clr_in,
  input  wire logic [ADDR_W-1:0]  busy_clr_addr_in,
  input  wire logic               rx_valid_in,
  input  wire aca_pdu_e           rx_kind_in,
  input  wire logic               rx_pf_in,
  input  wire logic               rx_for_me_in,
  input  wire logic [ADDR_W-1:0]  rx_src_in,
  output logic                    tx_valid_out,
  input  wire logic               tx_ready_in,
  output aca_pdu_e                tx_kind_out,
  output logic [ADDR_W-1:0]       tx_addr_out,
  output logic                    tx_pf_out,
  output logic                    tx_incl3_out,
  output logic                    ack_out,
  output logic [ADDR_W-1:0]       ack_addr_out,
  output logic                    fail_out,
  output logic [ADDR_W-1:0]       fail_addr_out
);

  typedef struct packed {
    logic [NUM_SLOTS-1:0]             active;
    logic [NUM_SLOTS-1:0]             pend;
    logic [NUM_SLOTS-1:0]             dead;
    logic [NUM_SLOTS-1:0]             incl3;
    logic [NUM_SLOTS-1:0][ADDR_W-1:0] addr;
    logic [NUM_BUSY-1:0]              bvalid;
    logic [NUM_BUSY-1:0][ADDR_W-1:0]  baddr;
    logic                             rsp_pend;
    logic                             rsp_urnr;
    logic [ADDR_W-1:0]                rsp_addr;
    logic                             tx_valid;
    aca_pdu_e                         tx_kind;
    logic [ADDR_W-1:0]                tx_addr;
    logic                             tx_pf;
    logic                             tx_incl3;
    logic                             ack;
    logic [ADDR_W-1:0]                ack_addr;
    logic                             fail;
    logic [ADDR_W-1:0]                fail_addr;
    logic [TICK_W-1:0]                tick_cnt;
  } aca_arq_s;

  aca_arq_s st;
  aca_arq_s next_st;

  logic                 rst_meta;
  logic                 rst_n;
  logic                 tick;
  logic [NUM_SLOTS-1:0] slot_start;
  logic [NUM_SLOTS-1:0] slot_retx;
  logic [NUM_SLOTS-1:0] slot_stop;
  logic [NUM_SLOTS-1:0] slot_expire;
  logic [NUM_SLOTS-1:0] slot_busy;
  logic [NUM_SLOTS-1:0][CNT_W-1:0] slot_count;
  logic                 rsp_in;
  logic                 poll_in;
  logic                 needs_slot;
  logic                 send_busy;
  logic                 free_found;
  logic                 send_go;

  // ==========================================================
  // Reset release
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // Exchange slots, one timer and count each
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : gen_slot
      aca_slot u_slot (
        .clk_in     (clk_in),
        .rst_n_in   (rst_n),
        .tick_in    (tick),
        .start_in   (slot_start[g]),
        .retx_in    (slot_retx[g]),
        .stop_in    (slot_stop[g]),
        .period_in  (ack_period_in),
        .count_out  (slot_count[g]),
        .expire_out (slot_expire[g])
      );
    end
  endgenerate

  assign tick    = (st.tick_cnt == TICK_W'(TICK_CYC - 1));
  assign rsp_in  = rx_valid_in && rx_pf_in &&
                   (rx_kind_in == PDU_URR || rx_kind_in == PDU_URNR);
  assign poll_in = rx_valid_in && rx_pf_in && rx_for_me_in &&
                   (rx_kind_in == PDU_UI);
  // Group, global and address 3 open no exchange
  assign needs_slot = (send_kind_in == DEST_INDIV ||
                       send_kind_in == DEST_SPECIAL) &&
                      (send_addr_in != SPECIAL3_ADDR);

  // ==========================================================
  // Busy lookups
  always_comb begin
    slot_busy  = '0;
    send_busy  = 1'b0;
    free_found = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (!st.active[i]) free_found = 1'b1;
      for (int j = 0; j < NUM_BUSY; j++) begin
        if (st.bvalid[j] && st.baddr[j] == st.addr[i]) slot_busy[i] = 1'b1;
      end
    end
    for (int j = 0; j < NUM_BUSY; j++) begin
      if (st.bvalid[j] && st.baddr[j] == send_addr_in) send_busy = 1'b1;
    end
  end

  assign send_ready_out = !st.tx_valid && !st.rsp_pend &&
                          !(|(st.pend & ~slot_busy)) &&
                          !send_busy &&
                          (free_found || !needs_slot);
  assign send_go = send_req_in && send_ready_out;

  // ==========================================================
  // Next state
  always_comb begin
    logic picked;
    logic bfree;
    next_st    = st;
    slot_start = '0;
    slot_retx  = '0;
    slot_stop  = '0;
    picked     = 1'b0;
    bfree      = 1'b0;
    next_st.ack  = 1'b0;
    next_st.fail = 1'b0;
    next_st.tick_cnt = tick ? '0 : st.tick_cnt + TICK_W'(1);
    if (st.tx_valid && tx_ready_in) next_st.tx_valid = 1'b0;

    for (int i = 0; i < NUM_SLOTS; i++) begin
      // Answer wins over a same-cycle expiry
      if (rsp_in && st.active[i] && !st.dead[i] &&
          st.addr[i] == rx_src_in) begin
        slot_stop[i]      = 1'b1;
        next_st.active[i] = 1'b0;
        next_st.pend[i]   = 1'b0;
        next_st.ack       = 1'b1;
        next_st.ack_addr  = rx_src_in;
      end else if (slot_expire[i] && st.active[i]) begin
        if (slot_count[i] == n4_in) next_st.dead[i] = 1'b1;
        else next_st.pend[i] = 1'b1;
      end
    end

    // Failures drain one per cycle so none is lost
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (st.dead[i] && !picked) begin
        picked            = 1'b1;
        next_st.dead[i]   = 1'b0;
        next_st.active[i] = 1'b0;
        next_st.fail      = 1'b1;
        next_st.fail_addr = st.addr[i];
      end
    end

    // Busy record: clear first so a same-cycle set wins
    for (int j = 0; j < NUM_BUSY; j++) begin
      if (st.bvalid[j] &&
          ((busy_clr_in && st.baddr[j] == busy_clr_addr_in) ||
           (rsp_in && rx_kind_in == PDU_URR &&
            st.baddr[j] == rx_src_in))) next_st.bvalid[j] = 1'b0;
    end
    if (rsp_in && rx_kind_in == PDU_URNR) begin
      for (int j = 0; j < NUM_BUSY; j++) begin
        if (next_st.bvalid[j] && st.baddr[j] == rx_src_in) bfree = 1'b1;
      end
      // Record full: the mark is dropped, a known limitation
      for (int j = 0; j < NUM_BUSY; j++) begin
        if (!next_st.bvalid[j] && !bfree) begin
          bfree             = 1'b1;
          next_st.bvalid[j] = 1'b1;
          next_st.baddr[j]  = rx_src_in;
        end
      end
    end

    // Answer a poll; one reply outstanding, polls arriving meanwhile are dropped
    if (poll_in && !st.rsp_pend) begin
      next_st.rsp_pend = 1'b1;
      next_st.rsp_urnr = local_busy_in && urnr_enable_in;
      next_st.rsp_addr = rx_src_in;
    end

    // Transmit: reply, then resend, then new send
    picked = 1'b0;
    if (!st.tx_valid) begin
      if (st.rsp_pend) begin
        next_st.rsp_pend = 1'b0;
        next_st.tx_valid = 1'b1;
        next_st.tx_kind  = st.rsp_urnr ? PDU_URNR : PDU_URR;
        next_st.tx_addr  = st.rsp_addr;
        next_st.tx_pf    = 1'b1;
        next_st.tx_incl3 = 1'b0;
      end else begin
        for (int i = 0; i < NUM_SLOTS; i++) begin
          if (st.pend[i] && !slot_busy[i] && !picked) begin
            picked           = 1'b1;
            slot_retx[i]     = 1'b1;
            next_st.pend[i]  = 1'b0;
            next_st.tx_valid = 1'b1;
            next_st.tx_kind  = PDU_UI;
            next_st.tx_addr  = st.addr[i];
            next_st.tx_pf    = 1'b1;
            next_st.tx_incl3 = st.incl3[i];
          end
        end
      end
    end

    if (send_go) begin
      next_st.tx_valid = 1'b1;
      next_st.tx_kind  = PDU_UI;
      next_st.tx_addr  = send_addr_in;
      next_st.tx_pf    = 1'b1;
      next_st.tx_incl3 = send_incl3_in;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        if (needs_slot && !st.active[i] && !picked) begin
          picked            = 1'b1;
          slot_start[i]     = 1'b1;
          next_st.active[i] = 1'b1;
          next_st.addr[i]   = send_addr_in;
          next_st.incl3[i]  = send_incl3_in;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tx_valid_out  = st.tx_valid;
  assign tx_kind_out   = st.tx_kind;
  assign tx_addr_out   = st.tx_addr;
  assign tx_pf_out     = st.tx_pf;
  assign tx_incl3_out  = st.tx_incl3;
  assign ack_out       = st.ack;
  assign ack_addr_out  = st.ack_addr;
  assign fail_out      = st.fail;
  assign fail_addr_out = st.fail_addr;

  // ==========================================================
  // Checks
  property p_reply_cause;
    @(posedge clk_in) disable iff (!rst_n)
    $rose(st.rsp_pend) |-> $past(poll_in);
  endproperty
  a_reply_cause: assert property (p_reply_cause)
    else $error("reply queued without a poll");

  property p_reply_urr;
    @(posedge clk_in) disable iff (!rst_n)
    (poll_in && !st.rsp_pend && !local_busy_in) |=>
      st.rsp_pend && !st.rsp_urnr && st.rsp_addr == $past(rx_src_in);
  endproperty
  a_reply_urr: assert property (p_reply_urr)
    else $error("poll not answered with URR to source");

  property p_reply_urnr;
    @(posedge clk_in) disable iff (!rst_n)
    (poll_in && !st.rsp_pend && local_busy_in && urnr_enable_in) |=>
      st.rsp_pend && st.rsp_urnr;
  endproperty
  a_reply_urnr: assert property (p_reply_urnr)
    else $error("busy poll not answered with URNR");

  property p_no_slot;
    @(posedge clk_in) disable iff (!rst_n)
    (send_go && !needs_slot) |=> (st.active & ~$past(st.active)) == '0;
  endproperty
  a_no_slot: assert property (p_no_slot)
    else $error("group or address 3 send opened an exchange");

  property p_open_slot;
    @(posedge clk_in) disable iff (!rst_n)
    (send_go && needs_slot && !rsp_in && st.dead == '0) |=>
      $countones(st.active) == $past($countones(st.active)) + 1;
  endproperty
  a_open_slot: assert property (p_open_slot)
    else $error("polled send did not open an exchange");

  property p_fail_cause;
    @(posedge clk_in) disable iff (!rst_n)
    $rose(st.fail) |-> $past(st.dead != '0);
  endproperty
  a_fail_cause: assert property (p_fail_cause)
    else $error("failure reported without a spent exchange");

  property p_ack_frees;
    @(posedge clk_in) disable iff (!rst_n)
    (rsp_in && (st.active & ~st.dead) != '0 && slot_stop != '0) |=>
      st.ack && st.ack_addr == $past(rx_src_in) &&
      (st.active & $past(slot_stop)) == '0;
  endproperty
  a_ack_frees: assert property (p_ack_frees)
    else $error("answer did not close its exchange");

  property p_busy_quiet;
    @(posedge clk_in) disable iff (!rst_n)
    (slot_retx != '0) |-> (slot_retx & slot_busy) == '0 ##1 st.tx_valid;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("resend to busy station");

  property p_urnr_marks;
    @(posedge clk_in) disable iff (!rst_n)
    (rsp_in && rx_kind_in == PDU_URNR && st.bvalid != '1) |=>
      st.bvalid != '0;
  endproperty
  a_urnr_marks: assert property (p_urnr_marks)
    else $error("URNR did not mark station busy");

endmodule

// ==== aca_pkg.sv ====
/*
 * Shared constants and types for the acknowledged connectionless
 * exchange block. Assumes one 25 MHz system clock.
 */
package aca_pkg;

  // ==========================================================
  // Addressing
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  SPECIAL3_ADDR = 8'h03;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 5;
  localparam int TIMER_W       = 16;
  localparam int CNT_W         = 4;

  // ==========================================================
  // Sizes
  localparam int NUM_SLOTS_DEF = 4;
  localparam int NUM_BUSY_DEF  = 4;

  // ==========================================================
  // PDU and destination kinds
  typedef enum logic [1:0] {
    PDU_UI,
    PDU_URR,
    PDU_URNR,
    PDU_OTHER
  } aca_pdu_e;

  typedef enum logic [1:0] {
    DEST_INDIV,
    DEST_SPECIAL,
    DEST_GROUP,
    DEST_GLOBAL
  } aca_dest_e;

endpackage

// ==== aca_slot.sv ====
/*
 * One exchange slot: acknowledgment timer and transmission count.
 * Assumes a one-cycle tick enable and controls that are one-hot.
 */
`timescale 1ns/100ps
module aca_slot
  import aca_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               tick_in,
  input  wire logic               start_in,
  input  wire logic               retx_in,
  input  wire logic               stop_in,
  input  wire logic [TIMER_W-1:0] period_in,
  output logic      [CNT_W-1:0]   count_out,
  output logic                    expire_out
);

  typedef struct packed {
    logic               run;
    logic [TIMER_W-1:0] timer;
    logic [CNT_W-1:0]   count;
  } aca_slot_s;

  aca_slot_s st;
  aca_slot_s next_st;

  assign count_out  = st.count;
  // Period of zero behaves as one tick
  assign expire_out = st.run && tick_in && (st.timer <= TIMER_W'(1));

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    if (stop_in) begin
      next_st.run   = 1'b0;
      next_st.count = '0;
    end else if (start_in) begin
      next_st.run   = 1'b1;
      next_st.timer = period_in;
      next_st.count = '0;
    end else if (retx_in) begin
      next_st.run   = 1'b1;
      next_st.timer = period_in;
      next_st.count = st.count + CNT_W'(1);
    end else if (expire_out) begin
      next_st.run = 1'b0;
    end else if (st.run && tick_in) begin
      next_st.timer = st.timer - TIMER_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Checks
  property p_retx_count;
    @(posedge clk_in) disable iff (!rst_n_in)
    (retx_in && !stop_in && !start_in) |=>
      (st.count == $past(st.count) + CNT_W'(1)) && st.run;
  endproperty
  a_retx_count: assert property (p_retx_count)
    else $error("retransmission did not bump the count");

  property p_start_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
    (start_in && !stop_in) |=> (st.count == '0) && st.run;
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("start did not clear count and run timer");

endmodule

// ==== aca_link_model.sv ====
/*
 * Far-side model: remote stations on the link. Takes UI PDUs, answers
 * polled ones with URR or URNR after a short delay, and injects polls.
 * Assumes one answer outstanding at a time and the bench clock.
 */
`timescale 1ns/100ps
module aca_link_model
  import aca_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic [1:0]        mode_in,
  input  wire logic              slow_in,
  input  wire logic              poll_in,
  input  wire logic [ADDR_W-1:0] poll_src_in,
  input  wire logic              tx_valid_in,
  input  wire aca_pdu_e          tx_kind_in,
  input  wire logic [ADDR_W-1:0] tx_addr_in,
  input  wire logic              tx_pf_in,
  output logic                   tx_ready_out,
  output logic                   rx_valid_out,
  output aca_pdu_e               rx_kind_out,
  output logic                   rx_pf_out,
  output logic                   rx_for_me_out,
  output logic [ADDR_W-1:0]      rx_src_out
);
  // ==========================================================
  // Link take and answers
  logic [1:0]        stall;
  logic [2:0]        delay;
  logic [ADDR_W-1:0] pend_addr;

  // Slow mode takes one PDU in four cycles
  assign tx_ready_out = !slow_in || (stall == 2'h3);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stall         <= 2'h0;
      delay         <= 3'h0;
      pend_addr     <= 8'h00;
      rx_valid_out  <= 1'b0;
      rx_kind_out   <= PDU_OTHER;
      rx_pf_out     <= 1'b0;
      rx_for_me_out <= 1'b0;
      rx_src_out    <= 8'h00;
    end else begin
      stall         <= stall + 2'h1;
      rx_valid_out  <= 1'b0;
      // Idle fields keep changing so stale values never pass as real
      rx_kind_out   <= aca_pdu_e'(~rx_kind_out);
      rx_pf_out     <= ~rx_pf_out;
      rx_for_me_out <= ~rx_for_me_out;
      rx_src_out    <= ~rx_src_out;
      if (delay != 3'h0)
        delay <= delay - 3'h1;
      if (poll_in) begin
        rx_valid_out  <= 1'b1;
        rx_kind_out   <= PDU_UI;
        rx_pf_out     <= 1'b1;
        rx_for_me_out <= 1'b1;
        rx_src_out    <= poll_src_in;
      end else if (delay == 3'h1) begin
        rx_valid_out  <= 1'b1;
        rx_kind_out   <= (mode_in == 2'h2) ? PDU_URNR : PDU_URR;
        rx_pf_out     <= 1'b1;
        rx_for_me_out <= 1'b0;
        rx_src_out    <= pend_addr;
      end
      if (tx_valid_in && tx_ready_out && tx_kind_in == PDU_UI && tx_pf_in &&
          tx_addr_in != SPECIAL3_ADDR && mode_in != 2'h0) begin
        delay     <= 3'h4;
        pend_addr <= tx_addr_in;
      end
    end
  end
endmodule

// ==== aca_arq_tb.sv ====
/*
 * Self-checking bench for the exchange engine: driver notes expected
 * PDUs, acks and failures in queues; a monitor compares them.
 * Assumes a 25 MHz clock and a small timer period and retry limit.
 */
`timescale 1ns/100ps
module aca_arq_tb;
  import aca_pkg::*;
  // ==========================================================
  // Signals
  logic              clk_in, reset_n_in, local_busy, urnr_en;
  logic              send_req, send_incl3, send_ready, busy_clr;
  logic [ADDR_W-1:0] send_addr, busy_clr_addr, tx_addr, ack_addr;
  logic [ADDR_W-1:0] fail_addr, poll_src, r;
  aca_dest_e         send_kind;
  logic              rx_valid, rx_pf, rx_for_me, tx_valid, tx_ready;
  aca_pdu_e          rx_kind, tx_kind;
  logic [ADDR_W-1:0] rx_src;
  logic              tx_pf, tx_incl3, ack, fail, slow, poll;
  logic [1:0]        mode;
  logic [10:0]       txq[$];
  logic [7:0]        ackq[$], failq[$];
  logic [10:0]       e;
  int                n_errors, num_checks;
  localparam logic [CNT_W-1:0] N4 = 4'h2;

  aca_arq i_aca_arq (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .ack_period_in(16'h0002), .n4_in(N4), .local_busy_in(local_busy),
    .urnr_enable_in(urnr_en), .send_req_in(send_req),
    .send_addr_in(send_addr), .send_kind_in(send_kind),
    .send_incl3_in(send_incl3), .send_ready_out(send_ready),
    .busy_clr_in(busy_clr), .busy_clr_addr_in(busy_clr_addr),
    .rx_valid_in(rx_valid), .rx_kind_in(rx_kind), .rx_pf_in(rx_pf),
    .rx_for_me_in(rx_for_me), .rx_src_in(rx_src), .tx_valid_out(tx_valid),
    .tx_ready_in(tx_ready), .tx_kind_out(tx_kind), .tx_addr_out(tx_addr),
    .tx_pf_out(tx_pf), .tx_incl3_out(tx_incl3), .ack_out(ack),
    .ack_addr_out(ack_addr), .fail_out(fail), .fail_addr_out(fail_addr));

  aca_link_model i_aca_link_model (.clk_in(clk_in), .rst_n_in(reset_n_in),
    .mode_in(mode), .slow_in(slow), .poll_in(poll), .poll_src_in(poll_src),
    .tx_valid_in(tx_valid), .tx_kind_in(tx_kind), .tx_addr_in(tx_addr),
    .tx_pf_in(tx_pf), .tx_ready_out(tx_ready), .rx_valid_out(rx_valid),
    .rx_kind_out(rx_kind), .rx_pf_out(rx_pf), .rx_for_me_out(rx_for_me),
    .rx_src_out(rx_src));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // ==========================================================
  // Tasks
  task automatic bad(input string msg);
    n_errors++;
    $display("BAD at %0t: %s", $time, msg);
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic send(input logic [7:0] a, input aca_dest_e k,
                      input logic i3);
    int n;
    send_req   <= 1'b1;
    send_addr  <= a;
    send_kind  <= k;
    send_incl3 <= i3;
    txq.push_back({PDU_UI, i3, a});
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (send_ready !== 1'b1 && n < 200);
    send_req <= 1'b0;
    if (n >= 200) begin
      bad("send never taken");
      final_report();
    end
    @(posedge clk_in);
  endtask

  task automatic drain(input int lim);
    int n;
    n = 0;
    while ((txq.size() + ackq.size() + failq.size()) != 0 && n < lim) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= lim) begin
      bad("expected output missing");
      final_report();
    end
    repeat (8) @(posedge clk_in);
  endtask

  // ==========================================================
  // Monitor
  always @(posedge clk_in) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      num_checks++;
      e = (txq.size() != 0) ? txq.pop_front() : 11'h7ff;
      if ({tx_kind, tx_incl3, tx_addr} !== e || tx_pf !== 1'b1)
        bad("unexpected PDU on link");
    end
    if (ack === 1'b1) begin
      num_checks++;
      if (ackq.size() == 0 || ack_addr !== ackq.pop_front())
        bad("unexpected ack");
    end
    if (fail === 1'b1) begin
      num_checks++;
      if (failq.size() == 0 || fail_addr !== failq.pop_front())
        bad("unexpected ack failure");
    end
  end

  initial begin
    repeat (90000) @(posedge clk_in);
    bad("run too long");
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    n_errors = 0;
    num_checks = 0;
    reset_n_in = 1'b0;
    {local_busy, urnr_en, send_req, send_incl3, busy_clr, poll} = 6'h00;
    {send_addr, busy_clr_addr, poll_src} = 24'h000000;
    send_kind = DEST_INDIV;
    mode = 2'h1;
    slow = 1'b0;
    void'($urandom(96480));
    r = 8'h10 + 8'($urandom & 32'h3f);
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    // Plain acknowledged exchange
    send(r, DEST_INDIV, 1'b0);
    ackq.push_back(r);
    drain(300);
    // Silent peer, slow link: N4 resends with address 3 kept, then failure
    mode <= 2'h0;
    slow <= 1'b1;
    send(r + 8'h01, DEST_INDIV, 1'b1);
    for (int i = 0; i < N4; i++)
      txq.push_back({PDU_UI, 1'b1, r + 8'h01});
    failq.push_back(r + 8'h01);
    drain(600);
    // Two exchanges overlapping keep their own timers and counts
    slow <= 1'b0;
    send(r + 8'h02, DEST_INDIV, 1'b0);
    repeat (10) @(posedge clk_in);
    send(r + 8'h03, DEST_INDIV, 1'b0);
    for (int i = 0; i < N4; i++) begin
      txq.push_back({PDU_UI, 1'b0, r + 8'h02});
      txq.push_back({PDU_UI, 1'b0, r + 8'h03});
    end
    failq.push_back(r + 8'h02);
    failq.push_back(r + 8'h03);
    drain(800);
    // Busy answer marks the station; sends to it are held off
    mode <= 2'h2;
    send(r + 8'h04, DEST_INDIV, 1'b0);
    ackq.push_back(r + 8'h04);
    drain(300);
    send_req  <= 1'b1;
    send_addr <= r + 8'h04;
    repeat (3) begin
      @(posedge clk_in);
      num_checks++;
      if (send_ready !== 1'b0)
        bad("send taken for busy station");
    end
    send_req <= 1'b0;
    repeat (200) @(posedge clk_in);
    busy_clr      <= 1'b1;
    busy_clr_addr <= r + 8'h04;
    @(posedge clk_in);
    busy_clr <= 1'b0;
    mode     <= 2'h1;
    @(posedge clk_in);
    send(r + 8'h04, DEST_INDIV, 1'b0);
    ackq.push_back(r + 8'h04);
    drain(300);
    // Group and address 3 open no exchange: one PDU each, no resend
    mode <= 2'h0;
    send(8'hf0, DEST_GROUP, 1'b0);
    send(SPECIAL3_ADDR, DEST_SPECIAL, 1'b0);
    send(8'hff, DEST_GLOBAL, 1'b0);
    repeat (300) @(posedge clk_in);
    drain(10);
    // Polls from a peer answered per local busy and URNR enable
    for (int i = 0; i < 3; i++) begin
      local_busy <= (i != 0);
      urnr_en    <= (i == 1);
      poll       <= 1'b1;
      poll_src   <= r + 8'h05 + 8'(i);
      txq.push_back({(i == 1) ? PDU_URNR : PDU_URR, 1'b0,
                     r + 8'h05 + 8'(i)});
      @(posedge clk_in);
      poll <= 1'b0;
      drain(100);
    end
    // No reply without a poll
    repeat (200) @(posedge clk_in);
    drain(10);
    final_report();
  end
endmodule
